// File: src/isrw_slave.sv
// Purpose: write-only two-wire slave that delivers sub-address/data pairs
// Assumes: scl_i clocks the link logic; sda sampled on scl rise
// Notes: start/stop seen by sda edges; writes cross to ref_clk_i by toggle
`include "isrw_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module isrw_slave
   import isrw_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic clk_en_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic addr_select_pin_zero,
   input wire logic addr_select_pin_one,
   output logic wr_valid_o,
   output isrw_wr_t wr_o,
   output logic bus_busy_o
);
   // link domain, clocked by scl
   logic sel0_q, sel1_q;
   logic start_tgl_q, stop_tgl_q;
   logic start_seen_q, stop_seen_q;
   isrw_state_t state_q, state_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] shift_q, shift_d;
   logic [7:0] sub_q;
   isrw_wr_t wr_link_q;
   logic wr_tgl_q;
   logic ack_q;
   logic [6:0] my_addr;
   wire byte_done = (cnt_q == `ISRW_ACK_SLOT);
   wire [7:0] rx_byte = shift_q;
   wire addr_hit;

   // address pins pass two flops before the start edge samples them
   logic pin_zero_s;
   logic pin_one_s;
   isrw_sync u_sync_p0 (.clk_i(ref_clk_i), .rst_i(rst_i), .en_i(clk_en_i),
      .d_i(addr_select_pin_zero), .q_o(pin_zero_s));
   isrw_sync u_sync_p1 (.clk_i(ref_clk_i), .rst_i(rst_i), .en_i(clk_en_i),
      .d_i(addr_select_pin_one), .q_o(pin_one_s));

   assign my_addr = {`ISRW_ADDR_FIXED, sel1_q, sel0_q};
   assign addr_hit = (rx_byte[7:1] == my_addr) && !rx_byte[`ISRW_RW_BIT];

   // pins sampled once per start in the link domain
   always_ff @(negedge sda_i or posedge rst_i) begin
      if (rst_i) begin
         start_tgl_q <= 1'b0;
         sel0_q <= 1'b0;
         sel1_q <= 1'b0;
      end else if (scl_i) begin
         start_tgl_q <= ~start_tgl_q;
         sel0_q <= pin_zero_s;
         sel1_q <= pin_one_s;
      end
   end

   always_ff @(posedge sda_i or posedge rst_i) begin
      if (rst_i) begin
         stop_tgl_q <= 1'b0;
      end else if (scl_i) begin
         stop_tgl_q <= ~stop_tgl_q;
      end
   end

   // start/stop edges seen at next scl rise: remember last toggle value
   wire start_new = (start_tgl_q != start_seen_q);
   wire stop_new = (stop_tgl_q != stop_seen_q);

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q + 4'h1;
      shift_d = {shift_q[6:0], sda_i};
      if (start_new) begin
         state_d = ISRW_ADDR;
         cnt_d = 4'h1;
         shift_d = {7'h00, sda_i};
      end else if (stop_new) begin
         state_d = ISRW_IDLE;
         cnt_d = `ISRW_CNT_RESET;
      end else if (byte_done) begin
         // byte boundary; after the data byte, further bytes stay in ISRW_DONE
         cnt_d = `ISRW_CNT_RESET;
         unique case (state_q)
            ISRW_ADDR: state_d = ack_q ? ISRW_SUB : ISRW_SKIP;
            ISRW_SUB: state_d = ISRW_DATA;
            ISRW_DATA: state_d = ISRW_DONE;
            ISRW_SKIP: state_d = ISRW_SKIP;
            ISRW_DONE: state_d = ISRW_DONE;
            ISRW_IDLE: state_d = ISRW_IDLE;
            default: state_d = ISRW_IDLE;
         endcase
      end
   end

   // sda sampled only on scl rise
   always_ff @(posedge scl_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= ISRW_IDLE;
         cnt_q <= `ISRW_CNT_RESET;
         shift_q <= `ISRW_BYTE_RESET;
         start_seen_q <= 1'b0;
         stop_seen_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         shift_q <= shift_d;
         start_seen_q <= start_tgl_q;
         stop_seen_q <= stop_tgl_q;
      end
   end

   // capture sub-address and data at the eighth bit
   wire eighth = (cnt_q == 4'h7) && !start_new && !stop_new;
   always_ff @(posedge scl_i or posedge rst_i) begin
      if (rst_i) begin
         sub_q <= `ISRW_BYTE_RESET;
         wr_link_q <= '0;
         wr_tgl_q <= 1'b0;
      end else if (eighth) begin
         if (state_q == ISRW_SUB) begin
            sub_q <= {shift_q[6:0], sda_i};
         end
         // data byte written to selected register
         if (state_q == ISRW_DATA) begin
            wr_link_q.sub_addr <= sub_q;
            wr_link_q.data <= {shift_q[6:0], sda_i};
            wr_tgl_q <= ~wr_tgl_q;
         end
      end
   end

   // ack decided on scl fall after the eighth bit, released after ninth
   // bytes that the slave acknowledges once it holds the bus
   function automatic logic acks_byte(input isrw_state_t s, input logic hit);
      return (s == ISRW_ADDR && hit) || s == ISRW_SUB || s == ISRW_DATA;
   endfunction

   wire ack_slot = (cnt_q == `ISRW_ACK_SLOT);
   wire ack_want = ack_slot && acks_byte(state_q, addr_hit);
   always_ff @(negedge scl_i or posedge rst_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         // ack only in slot when selected
         ack_q <= ack_want;
      end
   end
   assign sda_o = 1'b0;
   assign sda_oe_o = ack_q;

   // ref clock domain: write event crossing and busy flag
   logic wr_tgl_s, busy_lvl, wr_tgl_seen_q;
   logic start_s, stop_s, start_seen_r_q, stop_seen_r_q;
   logic busy_q;
   isrw_wr_t wr_q;
   isrw_sync u_sync_wr (.clk_i(ref_clk_i), .rst_i(rst_i), .en_i(clk_en_i),
      .d_i(wr_tgl_q), .q_o(wr_tgl_s));
   isrw_sync u_sync_st (.clk_i(ref_clk_i), .rst_i(rst_i), .en_i(clk_en_i),
      .d_i(start_tgl_q), .q_o(start_s));
   isrw_sync u_sync_sp (.clk_i(ref_clk_i), .rst_i(rst_i), .en_i(clk_en_i),
      .d_i(stop_tgl_q), .q_o(stop_s));
   assign busy_lvl = busy_q;

   wire wr_evt = (wr_tgl_s != wr_tgl_seen_q);
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_tgl_seen_q <= 1'b0;
         start_seen_r_q <= 1'b0;
         stop_seen_r_q <= 1'b0;
         busy_q <= 1'b0;
         wr_valid_o <= 1'b0;
         wr_q <= '0;
      end else if (clk_en_i) begin
         wr_tgl_seen_q <= wr_tgl_s;
         start_seen_r_q <= start_s;
         stop_seen_r_q <= stop_s;
         wr_valid_o <= wr_evt;
         // link word stable long before its toggle arrives
         if (wr_evt) begin
            wr_q <= wr_link_q;
         end
         if (start_s != start_seen_r_q) begin
            busy_q <= 1'b1;
         end else if (stop_s != stop_seen_r_q) begin
            busy_q <= 1'b0;
         end
      end
   end
   assign wr_o = wr_q;
   assign bus_busy_o = busy_lvl;

   a_ack_slot_only: assert property (@(negedge scl_i) disable iff (rst_i)
      sda_oe_o |-> $past(cnt_q) == `ISRW_ACK_SLOT) else $error("ack outside slot");
   a_no_ack_read: assert property (@(negedge scl_i) disable iff (rst_i)
      (state_q == ISRW_ADDR && cnt_q == `ISRW_ACK_SLOT && rx_byte[0]) |=> !sda_oe_o)
      else $error("read acked");
   a_skip_silent: assert property (@(negedge scl_i) disable iff (rst_i)
      (state_q == ISRW_SKIP) |=> !sda_oe_o) else $error("acked while deselected");
   a_wr_pulse_one: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      wr_valid_o |=> !wr_valid_o) else $error("write pulse too long");
   a_byte_count: assert property (@(posedge scl_i) disable iff (rst_i)
      cnt_q <= `ISRW_ACK_SLOT) else $error("bit count overrun");
   a_sub_to_data: assert property (@(posedge scl_i) disable iff (rst_i)
      (state_q == ISRW_SUB && byte_done && !start_new && !stop_new) |=> state_q == ISRW_DATA)
      else $error("sub-address not followed by data");
   a_start_restart: assert property (@(posedge scl_i) disable iff (rst_i)
      start_new |=> state_q == ISRW_ADDR && cnt_q == 4'h1) else $error("start missed");
   a_stop_idle: assert property (@(posedge scl_i) disable iff (rst_i)
      (stop_new && !start_new) |=> state_q == ISRW_IDLE) else $error("stop missed");
   c_write: cover property (@(posedge ref_clk_i) wr_valid_o);
   c_ack: cover property (@(negedge scl_i) sda_oe_o);
   c_skip: cover property (@(posedge scl_i) state_q == ISRW_SKIP);
   c_data_ack: cover property (@(negedge scl_i)
      byte_done && state_q == ISRW_DATA && acks_byte(state_q, addr_hit));
   c_restart: cover property (@(posedge scl_i) start_new && state_q == ISRW_DONE);

   // acknowledge slot and released line
   a_addr_acked: assert property (@(negedge scl_i) disable iff (rst_i)
      (state_q == ISRW_ADDR && byte_done && !rx_byte[`ISRW_RW_BIT] &&
      rx_byte[7:1] == {`ISRW_ADDR_FIXED, sel1_q, sel0_q}) |=> sda_oe_o)
      else $error("matching address not acked");
   a_ack_release: assert property (@(negedge scl_i) disable iff (rst_i)
      !byte_done |=> !sda_oe_o) else $error("sda held after slot");
   a_oe_drives_low: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      sda_oe_o |-> sda_o == 1'b0) else $error("ack drives high");
   a_idle_silent: assert property (@(negedge scl_i) disable iff (rst_i)
      (state_q == ISRW_IDLE) |=> !sda_oe_o) else $error("acked while idle");
   a_done_silent: assert property (@(negedge scl_i) disable iff (rst_i)
      (state_q == ISRW_DONE) |=> !sda_oe_o) else $error("extra byte acked");

   // byte framing and state flow
   a_cnt_wraps: assert property (@(posedge scl_i) disable iff (rst_i)
      (byte_done && !start_new && !stop_new) |=> cnt_q == `ISRW_CNT_RESET)
      else $error("bit count not restarted");
   a_skip_stays: assert property (@(posedge scl_i) disable iff (rst_i)
      (state_q == ISRW_SKIP && !start_new && !stop_new) |=> state_q == ISRW_SKIP)
      else $error("left skip without start");
   a_nack_to_skip: assert property (@(posedge scl_i) disable iff (rst_i)
      (state_q == ISRW_ADDR && byte_done && !ack_q && !start_new && !stop_new)
      |=> state_q == ISRW_SKIP) else $error("unmatched address not skipped");
   a_ack_to_sub: assert property (@(posedge scl_i) disable iff (rst_i)
      (state_q == ISRW_ADDR && byte_done && ack_q && !start_new && !stop_new)
      |=> state_q == ISRW_SUB) else $error("acked address not followed by sub");
   a_data_to_done: assert property (@(posedge scl_i) disable iff (rst_i)
      (state_q == ISRW_DATA && byte_done && !start_new && !stop_new)
      |=> state_q == ISRW_DONE) else $error("data byte not closed");
   a_sub_capture: assert property (@(posedge scl_i) disable iff (rst_i)
      (state_q == ISRW_SUB && eighth) |=> sub_q == $past({shift_q[6:0], sda_i}))
      else $error("sub-address not captured");
   a_data_capture: assert property (@(posedge scl_i) disable iff (rst_i)
      (state_q == ISRW_DATA && eighth) |=> wr_link_q.data == $past({shift_q[6:0], sda_i}))
      else $error("data byte not captured");

   // ref-domain crossing and busy flag
   a_busy_on_start: assert property (@(posedge ref_clk_i) disable iff (rst_i || !clk_en_i)
      (start_s != start_seen_r_q) |=> busy_q) else $error("busy not raised");
   a_busy_off_stop: assert property (@(posedge ref_clk_i) disable iff (rst_i || !clk_en_i)
      (stop_s != stop_seen_r_q && start_s == start_seen_r_q) |=> !busy_q)
      else $error("busy not cleared");
   a_valid_on_evt: assert property (@(posedge ref_clk_i) disable iff (rst_i || !clk_en_i)
      wr_evt |=> wr_valid_o && wr_o == $past(wr_link_q)) else $error("write not delivered");
   a_wr_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !wr_evt |=> $stable(wr_o)) else $error("write word changed");
endmodule
`default_nettype wire

// File: src/isrw_consts.svh
// Purpose: constants of the two-wire register writer
// Assumes: included by bare name
// Notes: definitions only
`ifndef ISRW_CONSTS_SVH
`define ISRW_CONSTS_SVH
`define ISRW_ADDR_FIXED 5'h13
`define ISRW_ADDR_FIXED_MSB 6
`define ISRW_ADDR_FIXED_LSB 2
`define ISRW_RW_BIT 0
`define ISRW_BITS_PER_BYTE 4'h8
`define ISRW_ACK_SLOT 4'h8
`define ISRW_BYTE_RESET 8'h00
`define ISRW_CNT_RESET 4'h0
`endif

// File: src/isrw_pkg.sv
// Purpose: types of the two-wire register writer
// Assumes: nothing
// Notes: states use gray codes from idle to data; data to done changes two bits
package isrw_pkg;
   typedef enum logic [2:0] {
      ISRW_IDLE = 3'h0,
      ISRW_ADDR = 3'h1,
      ISRW_SUB = 3'h3,
      ISRW_DATA = 3'h2,
      ISRW_SKIP = 3'h6,
      ISRW_DONE = 3'h7
   } isrw_state_t;
   typedef struct packed {
      logic [7:0] sub_addr;
      logic [7:0] data;
   } isrw_wr_t;
endpackage

// File: src/isrw_sync.sv
// Purpose: two-flop level synchroniser
// Assumes: d_i asynchronous to clk_i
// Notes: first stage read only by second
`timescale 1ns/1ps
`default_nettype none
module isrw_sync (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   input wire logic d_i,
   output logic q_o
);
   logic meta_q;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= 1'b0;
         q_o <= 1'b0;
      end else if (en_i) begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule
`default_nettype wire

// File: tb/isrw_master.sv
// Purpose: behavioural bus master for the two-wire register writer
// Assumes: sda has a pull-up; sda_low_o high pulls the line low
// Notes: scl stands high outside frames; 80 ns bit period
`timescale 1ns/1ps
`default_nettype none
module isrw_master (
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_low_o
);
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic start();
      sda_low_o = 1'b0;
      #20 scl_o = 1'b1;
      #40 sda_low_o = 1'b1;
      #40 scl_o = 1'b0;
   endtask
   // sda moves only while scl low
   task automatic send_bit(input logic b);
      #10 sda_low_o = ~b;
      #30 scl_o = 1'b1;
      #40 scl_o = 1'b0;
   endtask
   // msb first, then a released ack slot
   task automatic send_byte(input logic [7:0] v, output logic ack);
      for (int i = 7; i >= 0; i--) send_bit(v[i]);
      #10 sda_low_o = 1'b0;
      #30 scl_o = 1'b1;
      ack = ~sda_i;
      #40 scl_o = 1'b0;
   endtask
   task automatic stop();
      #10 sda_low_o = 1'b1;
      #30 scl_o = 1'b1;
      #40 sda_low_o = 1'b0;
      #40;
   endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Purpose: self-checking bench of the two-wire register writer
// Assumes: master model drives scl and sda; pull-up on sda
// Notes: queue model holds the expected register writes
`include "isrw_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench
   import isrw_pkg::*;
;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic pin0 = 1'b0;
   logic pin1 = 1'b0;
   logic scl, sda_low, sda, sda_o, sda_oe, wr_valid, busy, ack;
   isrw_wr_t wr;
   isrw_wr_t exp_q[$];
   int fail_count = 0;
   int check_count = 0;
   always #2.5 ref_clk_i = ~ref_clk_i;
   assign sda = (sda_oe ? sda_o : 1'b1) & ~sda_low;
   isrw_master m (.sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
   isrw_slave dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(1'b1), .scl_i(scl),
      .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_select_pin_zero(pin0),
      .addr_select_pin_one(pin1), .wr_valid_o(wr_valid), .wr_o(wr), .bus_busy_o(busy));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   always @(posedge ref_clk_i) begin
      if (wr_valid === 1'b1) begin
         check("write", wr, exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx);
      end
   end
   task automatic xfer(input logic [6:0] a, input logic rw, input logic hit);
      logic [7:0] s;
      logic [7:0] d;
      s = 8'($urandom);
      d = 8'($urandom);
      m.start();
      check("busy", {15'h0, busy}, 16'h1);
      m.send_byte({a, rw}, ack);
      check("addr ack", {15'h0, ack}, {15'h0, hit});
      if (hit) exp_q.push_back({s, d});
      m.send_byte(s, ack);
      check("sub ack", {15'h0, ack}, {15'h0, hit});
      m.send_byte(d, ack);
      check("data ack", {15'h0, ack}, {15'h0, hit});
   endtask
   initial begin
      void'($urandom(32'h2385c543));
      repeat (16) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(posedge ref_clk_i);
      check("reset write", wr, 16'h0000);
      check("reset flags", {13'h0, wr_valid, busy, sda_oe}, 16'h0000);
      for (int p = 0; p < 4; p++) begin
         @(posedge ref_clk_i);
         {pin1, pin0} <= 2'(p);
         @(posedge ref_clk_i);
         xfer({`ISRW_ADDR_FIXED, pin1, pin0}, 1'b0, 1'b1);
         xfer({`ISRW_ADDR_FIXED, pin0, pin1}, 1'b0, pin0 == pin1);
         xfer({`ISRW_ADDR_FIXED ^ 5'h01, pin1, pin0}, 1'b0, 1'b0);
         xfer({`ISRW_ADDR_FIXED, pin1, pin0}, 1'b1, 1'b0);
         xfer({`ISRW_ADDR_FIXED, pin1, pin0}, 1'b0, 1'b1);
         m.send_byte(8'($urandom), ack);
         check("extra ack", {15'h0, ack}, 16'h0);
         m.stop();
         repeat (8) @(posedge ref_clk_i);
         check("busy after stop", {15'h0, busy}, 16'h0);
      end
      repeat (10) @(posedge ref_clk_i);
      check("pending writes", 16'(exp_q.size()), 16'h0);
      finish_test();
   end
   initial begin
      #100000;
      fail_count++;
      finish_test();
   end
endmodule
`default_nettype wire
